/* pfs_pin_select.sv */
/*
  Pin function select for ports four, five and six: port registers, the
  analog input enable register, and the steering of each shared port four and six pin
  between port use and its peripheral, with an Avalon-MM register slave.
  Assumes pin inputs synchronous to core_clk, a synchronous active-high
  reset, and peripherals that present their own output enables.

*/
`timescale 1ns/10ps
`default_nettype none
module pfs_pin_select #(
  parameter int ADDR_W = 6
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire pfs_pkg::pfs_ser_s second_uart,
  input wire pfs_pkg::pfs_ser_s ext_serial,
  input wire logic [7:0] port_four_pin_in,
  output var pfs_pkg::pfs_pin_s port_four_pin,
  input wire logic [6:0] port_five_pin_in,
  output logic [6:0] port_five_pin_out,
  output logic [6:0] port_five_pin_oe,
  input wire logic [7:0] port_six_pin_in,
  output var pfs_pkg::pfs_pin_s port_six_pin,
  output logic [7:0] analog_channel_connect,
  output logic second_uart_clock_in,
  output logic ext_serial_clock_in,
  output logic ext_serial_rx_pin,
  output logic [3:0] ext_irq_inputs_four_to_seven,
  output logic adc_start_trigger_pin,
  output logic reload_timer_zero_event_pin
);
  import pfs_pkg::*;

  // The decoder compares against six-bit offsets, so narrower buses cannot reach the map.
  if (ADDR_W < 6) begin : g_bad_addr
    $error("pfs_pin_select: ADDR_W must be at least 6");
  end

  logic [7:0] p4_data;
  logic [7:0] p4_dir;
  logic [6:0] p5_data;
  logic [6:0] p5_dir;
  logic [7:0] p6_data;
  logic [7:0] p6_dir;
  logic [7:0] analog_en;
  logic [7:0] p4_in_q;
  logic [6:0] p5_in_q;
  logic [7:0] p6_in_q;
  logic [5:0] ofs;
  logic bus_req;
  logic wr_take;
  logic [31:0] next_readdata;

  assign ofs = avs_address[5:0];
  assign bus_req = avs_read | avs_write;
  // A write lands only at the edge where the master sees waitrequest low.
  assign wr_take = avs_write & ~avs_waitrequest & avs_byteenable[0];

  // Waitrequest idles high and drops for one cycle per request, so every
  // access completes on the second edge; this keeps all outputs registered.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else if (bus_req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read data is decoded from the address; unmapped offsets read as zero.
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (ofs)
      OFS_P4_DATA: next_readdata[7:0] = p4_data;
      OFS_P4_DIR: next_readdata[7:0] = p4_dir;
      OFS_P5_DATA: next_readdata[6:0] = p5_data;
      OFS_P5_DIR: next_readdata[6:0] = p5_dir;
      OFS_P6_DATA: next_readdata[7:0] = p6_data;
      OFS_P6_DIR: next_readdata[7:0] = p6_dir;
      OFS_ANALOG_EN: next_readdata[7:0] = analog_en;
      OFS_P4_PINS: next_readdata[7:0] = p4_in_q;
      OFS_P5_PINS: next_readdata[6:0] = p5_in_q;
      OFS_P6_PINS: next_readdata[7:0] = p6_in_q;
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // Read data is captured while waitrequest is high and stands through the completing edge.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  // Port data and direction registers; a direction bit of one means output.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      p4_data <= RST_DATA;
      p4_dir <= RST_DIR;
      p5_data <= RST_DATA[6:0];
      p5_dir <= RST_DIR[6:0];
      p6_data <= RST_DATA;
      p6_dir <= RST_DIR;
    end else if (wr_take) begin
      case (ofs)
        OFS_P4_DATA: p4_data <= avs_writedata[7:0];
        OFS_P4_DIR: p4_dir <= avs_writedata[7:0];
        OFS_P5_DATA: p5_data <= avs_writedata[6:0];
        OFS_P5_DIR: p5_dir <= avs_writedata[6:0];
        OFS_P6_DATA: p6_data <= avs_writedata[7:0];
        OFS_P6_DIR: p6_dir <= avs_writedata[7:0];
        default: p4_data <= p4_data;
      endcase
    end
  end

  // Analog input enable: a one hands the port six pin to the converter.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      analog_en <= RST_ANALOG_EN;
    end else if (wr_take && ofs == OFS_ANALOG_EN) begin
      analog_en <= avs_writedata[7:0];
    end
  end

  // Pin levels are sampled once so every consumer sees the same value.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      p4_in_q <= 8'h00;
      p5_in_q <= 7'h00;
      p6_in_q <= 8'h00;
    end else begin
      p4_in_q <= port_four_pin_in;
      p5_in_q <= port_five_pin_in;
      p6_in_q <= port_six_pin_in;
    end
  end

  // Port four: low nibble is plain port; each upper bit yields to its
  // peripheral while that peripheral enables its output. The port latch
  // keeps its value meanwhile and returns when the peripheral lets go.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      port_four_pin.out <= 8'h00;
      port_four_pin.oe <= 8'h00;
    end else begin
      port_four_pin.out[3:0] <= p4_data[3:0];
      port_four_pin.oe[3:0] <= p4_dir[3:0];
      port_four_pin.out[P4_UART_CLK] <= second_uart.clk_oe ? second_uart.clk_out
                                                           : p4_data[P4_UART_CLK];
      port_four_pin.oe[P4_UART_CLK] <= second_uart.clk_oe | p4_dir[P4_UART_CLK];
      port_four_pin.out[P4_UART_TX] <= second_uart.tx_oe ? second_uart.tx_out
                                                         : p4_data[P4_UART_TX];
      port_four_pin.oe[P4_UART_TX] <= second_uart.tx_oe | p4_dir[P4_UART_TX];
      port_four_pin.out[P4_EXT_TX] <= ext_serial.tx_oe ? ext_serial.tx_out
                                                       : p4_data[P4_EXT_TX];
      port_four_pin.oe[P4_EXT_TX] <= ext_serial.tx_oe | p4_dir[P4_EXT_TX];
      port_four_pin.out[P4_EXT_CLK] <= ext_serial.clk_oe ? ext_serial.clk_out
                                                         : p4_data[P4_EXT_CLK];
      port_four_pin.oe[P4_EXT_CLK] <= ext_serial.clk_oe | p4_dir[P4_EXT_CLK];
    end
  end

  // Clock pins are two-way: the sampled level feeds the serial units for
  // external clock operation.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      second_uart_clock_in <= 1'b0;
      ext_serial_clock_in <= 1'b0;
    end else begin
      second_uart_clock_in <= p4_in_q[P4_UART_CLK];
      ext_serial_clock_in <= p4_in_q[P4_EXT_CLK];
    end
  end

  // Port five is always a port; the input-only peripherals just listen.
  // Nothing stops an output direction, so a peripheral then hears the
  // port's own drive, which is why software must select input there.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      port_five_pin_out <= 7'h00;
      port_five_pin_oe <= 7'h00;
      ext_serial_rx_pin <= 1'b0;
      ext_irq_inputs_four_to_seven <= 4'h0;
      adc_start_trigger_pin <= 1'b0;
      reload_timer_zero_event_pin <= 1'b0;
    end else begin
      port_five_pin_out <= p5_data;
      port_five_pin_oe <= p5_dir;
      ext_serial_rx_pin <= p5_in_q[P5_EXT_RX];
      ext_irq_inputs_four_to_seven <= p5_in_q[P5_IRQ_LO +: 4];
      adc_start_trigger_pin <= p5_in_q[P5_ADC_TRIG];
      reload_timer_zero_event_pin <= p5_in_q[P5_TIMER_EVT];
    end
  end

  // Port six, one slice per bit: analog use connects the channel and
  // withdraws the port driver; port use restores data and direction.
  for (genvar i = 0; i < PORT6_W; i++) begin : g_p6
    always_ff @(posedge core_clk) begin
      if (reset) begin
        analog_channel_connect[i] <= 1'b0;
        port_six_pin.out[i] <= 1'b0;
        port_six_pin.oe[i] <= 1'b0;
      end else begin
        analog_channel_connect[i] <= analog_en[i];
        port_six_pin.out[i] <= p6_data[i];
        port_six_pin.oe[i] <= p6_dir[i] & ~analog_en[i];
      end
    end
  end

endmodule
`default_nettype wire

/* pfs_pin_select_checker.sv */
/* Checker for the pin function select block: pin ownership and input paths.
   Assumes it is bound to pfs_pin_select and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module pfs_pin_select_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic avs_waitrequest,
  input wire pfs_pkg::pfs_ser_s second_uart,
  input wire pfs_pkg::pfs_ser_s ext_serial,
  input wire pfs_pkg::pfs_pin_s port_four_pin,
  input wire pfs_pkg::pfs_pin_s port_six_pin,
  input wire logic [7:0] analog_channel_connect,
  input wire logic [6:0] port_five_pin_in,
  input wire logic ext_serial_rx_pin,
  input wire logic [3:0] ext_irq_inputs_four_to_seven,
  input wire logic adc_start_trigger_pin,
  input wire logic reload_timer_zero_event_pin
);
  import pfs_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // An owned pin copies its peripheral one cycle later, whatever the port latch holds.
  property p_uclk;
    second_uart.clk_oe |=> port_four_pin.oe[4] && port_four_pin.out[4] == $past(second_uart.clk_out);
  endproperty
  property p_utx;
    second_uart.tx_oe |=> port_four_pin.oe[5] && port_four_pin.out[5] == $past(second_uart.tx_out);
  endproperty
  property p_etx;
    ext_serial.tx_oe |=> port_four_pin.oe[6] && port_four_pin.out[6] == $past(ext_serial.tx_out);
  endproperty
  property p_eclk;
    ext_serial.clk_oe |=> port_four_pin.oe[7] && port_four_pin.out[7] == $past(ext_serial.clk_out);
  endproperty
  // An analog pin must never be driven, or it would fight the sampled voltage.
  property p_an;
    (analog_channel_connect & port_six_pin.oe) == 8'h00;
  endproperty
  // Input paths are two stages deep; skip the cycles that still see reset.
  property p_irq;
    !$past(reset) && !$past(reset, 2) |->
      ext_irq_inputs_four_to_seven == $past(port_five_pin_in[4:1], 2);
  endproperty
  property p_misc;
    !$past(reset) && !$past(reset, 2) |-> {reload_timer_zero_event_pin, adc_start_trigger_pin,
      ext_serial_rx_pin} == {$past(port_five_pin_in[6:5], 2), $past(port_five_pin_in[0], 2)};
  endproperty
  property p_wait;
    $fell(avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_uclk: assert property (p_uclk) else $error("uart clock pin not owned");
  a_utx: assert property (p_utx) else $error("uart data pin not owned");
  a_etx: assert property (p_etx) else $error("ext data pin not owned");
  a_eclk: assert property (p_eclk) else $error("ext clock pin not owned");
  a_an: assert property (p_an) else $error("analog pin driven");
  a_irq: assert property (p_irq) else $error("irq inputs wrong");
  a_misc: assert property (p_misc) else $error("port five inputs wrong");
  a_wait: assert property (p_wait) else $error("waitrequest low too long");
  c_own: cover property (second_uart.clk_oe ##1 !second_uart.clk_oe);
  c_an: cover property (analog_channel_connect == 8'hF0);
  c_bus: cover property ($fell(avs_waitrequest));
endmodule
bind pfs_pin_select pfs_pin_select_checker u_chk (.core_clk(core_clk), .reset(reset),
  .avs_waitrequest(avs_waitrequest), .second_uart(second_uart), .ext_serial(ext_serial),
  .port_four_pin(port_four_pin), .port_six_pin(port_six_pin),
  .analog_channel_connect(analog_channel_connect), .port_five_pin_in(port_five_pin_in),
  .ext_serial_rx_pin(ext_serial_rx_pin),
  .ext_irq_inputs_four_to_seven(ext_irq_inputs_four_to_seven),
  .adc_start_trigger_pin(adc_start_trigger_pin),
  .reload_timer_zero_event_pin(reload_timer_zero_event_pin));
`default_nettype wire

/* pfs_pin_select_tb.sv */
/* Self-checking bench for the pin function select block.
   Assumes the package and the bound checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module pfs_pin_select_tb;
  import pfs_pkg::*;
  logic core_clk = 0, reset = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [5:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  pfs_ser_s second_uart = 0, ext_serial = 0;
  logic [7:0] port_four_pin_in = 0, port_six_pin_in = 0, analog_channel_connect;
  logic [6:0] port_five_pin_in = 0, port_five_pin_out, port_five_pin_oe;
  pfs_pin_s port_four_pin, port_six_pin;
  logic uck, eck, erx, adc, tmr;
  logic [3:0] irq;
  int err_count = 0, n_compared = 0, cyc = 0;
  pfs_pin_select DUT (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .second_uart(second_uart), .ext_serial(ext_serial), .port_four_pin_in(port_four_pin_in),
    .port_four_pin(port_four_pin), .port_five_pin_in(port_five_pin_in),
    .port_five_pin_out(port_five_pin_out), .port_five_pin_oe(port_five_pin_oe),
    .port_six_pin_in(port_six_pin_in), .port_six_pin(port_six_pin),
    .analog_channel_connect(analog_channel_connect), .second_uart_clock_in(uck),
    .ext_serial_clock_in(eck), .ext_serial_rx_pin(erx), .ext_irq_inputs_four_to_seven(irq),
    .adc_start_trigger_pin(adc), .reload_timer_zero_event_pin(tmr));
  always #20 core_clk = ~core_clk;
  // A hang is cut short well beyond the roughly 110 cycles the tests need.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus request, held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic settle();
    repeat (3) @(posedge core_clk);
  endtask
  task automatic t_reg();
    for (int a = 0; a < 7; a++) begin
      bus(0, 6'(a * 4), 8'h00);
      chk(q, 32'h00000000);
    end
    bus(1, OFS_P4_PINS, 8'hFF);
    // A write to the read-only pins register must not spill into the port latch.
    bus(0, OFS_P4_DATA, 8'h00);
    chk(q, 32'h00000000);
    bus(0, 6'h28, 8'h00);
    chk(q, 32'h00000000);
    $display("test reg done");
  endtask
  task automatic t_periph();
    bus(1, OFS_P4_DIR, 8'h0F);
    second_uart <= 4'hF;
    ext_serial <= 4'h5;
    port_four_pin_in <= 8'h90;
    bus(1, OFS_P4_DATA, 8'hA5);
    settle();
    chk(port_four_pin, 16'h35FF);
    chk({uck, eck}, 2'h3);
    second_uart <= 4'h0;
    ext_serial <= 4'h0;
    settle();
    chk(port_four_pin, 16'hA50F);
    bus(0, OFS_P4_PINS, 8'h00);
    chk(q, 32'h00000090);
    bus(1, OFS_P4_DATA, 8'h00);
    second_uart <= 4'hC;
    ext_serial <= 4'h3;
    // A different pin pattern shows the external serial clock input is not stuck high.
    port_four_pin_in <= 8'h10;
    settle();
    chk(port_four_pin, 16'h505F);
    chk({uck, eck}, 2'h2);
    $display("test periph done");
  endtask
  task automatic t_analog();
    port_six_pin_in <= 8'hA5;
    bus(1, OFS_P6_DIR, 8'hFF);
    bus(1, OFS_P6_DATA, 8'h3C);
    bus(1, OFS_ANALOG_EN, 8'hF0);
    settle();
    chk({analog_channel_connect, port_six_pin.oe, port_six_pin.out[3:0]}, 20'hF00FC);
    bus(1, OFS_ANALOG_EN, 8'h00);
    settle();
    chk({analog_channel_connect, port_six_pin.oe}, 16'h00FF);
    bus(0, OFS_P6_PINS, 8'h00);
    chk(q, 32'h000000A5);
    $display("test analog done");
  endtask
  task automatic t_port5();
    bus(1, OFS_P5_DIR, 8'h00);
    port_five_pin_in <= 7'h55;
    settle();
    chk({tmr, adc, irq, erx}, 7'h55);
    bus(1, OFS_P5_DIR, 8'h7F);
    bus(1, OFS_P5_DATA, 8'h2A);
    settle();
    chk({port_five_pin_oe, port_five_pin_out}, 14'h3FAA);
    bus(0, OFS_P5_PINS, 8'h00);
    chk(q, 32'h00000055);
    $display("test port5 done");
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    t_reg();
    t_periph();
    t_analog();
    t_port5();
    wrap_up();
  end
endmodule
`default_nettype wire

/* pfs_pkg.sv */
/*
  Package for the port four to six pin function select block.
  Holds register offsets, reset values, widths and the packed carriers
  that group a serial unit's pin controls and a port's pin drive.
*/
`default_nettype none
package pfs_pkg;

  // Widths of the three ports; port five has seven shared bits.
  localparam int PORT4_W = 8;
  localparam int PORT5_W = 7;
  localparam int PORT6_W = 8;

  // Byte addresses of the word-aligned registers.
  localparam logic [5:0] OFS_P4_DATA = 6'h00;
  localparam logic [5:0] OFS_P4_DIR = 6'h04;
  localparam logic [5:0] OFS_P5_DATA = 6'h08;
  localparam logic [5:0] OFS_P5_DIR = 6'h0C;
  localparam logic [5:0] OFS_P6_DATA = 6'h10;
  localparam logic [5:0] OFS_P6_DIR = 6'h14;
  localparam logic [5:0] OFS_ANALOG_EN = 6'h18;
  localparam logic [5:0] OFS_P4_PINS = 6'h1C;
  localparam logic [5:0] OFS_P5_PINS = 6'h20;
  localparam logic [5:0] OFS_P6_PINS = 6'h24;

  // Reset values: all pins inputs, latches low, port six in port use.
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_ANALOG_EN = 8'h00;

  // Shared bit positions on port four.
  localparam int P4_UART_CLK = 4;
  localparam int P4_UART_TX = 5;
  localparam int P4_EXT_TX = 6;
  localparam int P4_EXT_CLK = 7;

  // Shared bit positions on port five.
  localparam int P5_EXT_RX = 0;
  localparam int P5_IRQ_LO = 1;
  localparam int P5_ADC_TRIG = 5;
  localparam int P5_TIMER_EVT = 6;

  // Output controls a serial unit presents to its two shared pins.
  typedef struct packed {
    logic clk_out;
    logic clk_oe;
    logic tx_out;
    logic tx_oe;
  } pfs_ser_s;

  // Drive of an eight-bit port: level and output enable per bit.
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pfs_pin_s;

endpackage
`default_nettype wire
